// ===== design/ftm_period_monitor.sv
/*
  ftm_period_monitor: fan tachometer period monitor with three 8-bit
  registers plus an interrupt mask register.
  assumes enables for 16/8/4/2/32 KHz and the monitor enable come from
  surrounding device logic, all synchronous to ref_clk.
*/
module ftm_period_monitor
  import ftm_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       mon_en,
  input  wire logic       tick_16k,
  input  wire logic       tick_8k,
  input  wire logic       tick_4k,
  input  wire logic       tick_2k,
  input  wire logic       tick_32k,
  input  wire logic       tach_pulse_in,
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            irq
);
  import ftm_pkg::*;

  ftm_state_s st_ff;
  ftm_state_s nxt_st;
  ftm_req_s   req;
  logic       tach_filt;
  logic       tach_sel;
  logic       count_tick;
  logic       rise;
  logic       wr_ctrl;
  logic       rd_speed;
  logic       ovf_evt;
  logic       thr_evt;

  function automatic logic [7:0] ctrl_word(input ftm_state_s s);
    ctrl_word = {1'b0, s.csel, s.filt_dis, s.irq_en,
                 s.overflow, s.over_thr, s.ready};
  endfunction

  ftm_glitch_filter u_filt (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .tick_en  (tick_32k),
    .raw_in   (tach_pulse_in),
    .filt_out (tach_filt)
  );

  always_comb begin
    req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  end

  // filter choice inputs taken as synchronous
  assign tach_sel = st_ff.filt_dis ? tach_pulse_in : tach_filt;

  always_comb begin
    case (st_ff.csel)
      FTM_CSEL_16K: count_tick = tick_16k;
      FTM_CSEL_8K:  count_tick = tick_8k;
      FTM_CSEL_4K:  count_tick = tick_4k;
      FTM_CSEL_2K:  count_tick = tick_2k;
      default:      count_tick = 1'b0;
    endcase
  end

  assign rise     = tach_sel & ~st_ff.tach_prev;
  assign wr_ctrl  = req.wr && req.addr == FTM_OFS_CTRL;
  assign rd_speed = req.rd && req.addr == FTM_OFS_READING;
  // count stalls while overflow stands, resumes once cleared
  assign ovf_evt  = mon_en && !st_ff.overflow && count_tick &&
                    st_ff.counter == 8'hFF && !rise;
  assign thr_evt  = mon_en && st_ff.armed && rise && !st_ff.over_thr &&
                    st_ff.counter > st_ff.threshold;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tach_prev = tach_sel;
    nxt_st.rdata = 8'h00;
    // register writes; csel and filter held by software while on
    if (req.wr) begin
      case (req.addr)
        FTM_OFS_THRESHOLD: nxt_st.threshold = req.wdata;
        FTM_OFS_CTRL: begin
          nxt_st.csel     = req.wdata[FTM_BIT_CSEL_LO +: 2];
          nxt_st.filt_dis = req.wdata[FTM_BIT_FILT_DIS];
          nxt_st.irq_en   = req.wdata[FTM_BIT_IRQ_EN];
          if (req.wdata[FTM_BIT_OVERFLOW]) nxt_st.overflow = 1'b0;
          if (req.wdata[FTM_BIT_OVER_THR]) nxt_st.over_thr = 1'b0;
        end
        FTM_OFS_IRQ_STAT: begin
          nxt_st.irq_mask_ovf = req.wdata[FTM_BIT_OVERFLOW];
          nxt_st.irq_mask_thr = req.wdata[FTM_BIT_OVER_THR];
        end
        default: ;
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        FTM_OFS_THRESHOLD: nxt_st.rdata = st_ff.threshold;
        FTM_OFS_READING:   nxt_st.rdata = st_ff.reading;
        FTM_OFS_CTRL:      nxt_st.rdata = ctrl_word(st_ff);
        FTM_OFS_IRQ_STAT:  nxt_st.rdata = {5'h00, st_ff.irq_mask_ovf,
                                           st_ff.irq_mask_thr, 1'b0};
        default:           nxt_st.rdata = 8'h00;
      endcase
    end
    if (rd_speed) nxt_st.ready = 1'b0;
    if (!mon_en) begin
      // disabled: zeroed and disarmed
      nxt_st.counter = 8'h00;
      nxt_st.reading = 8'h00;
      nxt_st.armed   = 1'b0;
    end else if (!st_ff.overflow || (wr_ctrl &&
                 req.wdata[FTM_BIT_OVERFLOW])) begin
      if (rise && !st_ff.armed) begin
        // first edge only starts the count
        nxt_st.counter = 8'h00;
        nxt_st.armed   = 1'b1;
      end else if (rise && st_ff.armed && !st_ff.over_thr) begin
        nxt_st.reading = st_ff.counter;
        nxt_st.counter = 8'h00;
        nxt_st.ready   = 1'b1;
      end else if (ovf_evt) begin
        nxt_st.reading = 8'h00;
        nxt_st.counter = 8'h00;
        nxt_st.armed   = 1'b0;
      end else if (count_tick && st_ff.armed) begin
        nxt_st.counter = st_ff.counter + 8'h01;
      end
    end
    // sets win over same-cycle clears
    if (thr_evt) nxt_st.over_thr = 1'b1;
    if (ovf_evt) begin
      nxt_st.overflow = 1'b1;
      nxt_st.ready    = 1'b0;
    end
    // mask of zero passes an event; mask register defaults open
    nxt_st.irq = nxt_st.irq_en &&
                 ((nxt_st.overflow && !nxt_st.irq_mask_ovf) ||
                  (nxt_st.over_thr && !nxt_st.irq_mask_thr));
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_ff           <= '0;
      st_ff.threshold <= FTM_RST_THRESHOLD;
      st_ff.csel      <= FTM_RST_CSEL;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign irq       = st_ff.irq;

  a_ovf_sets_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ovf_evt |=> st_ff.overflow && st_ff.reading == 8'h00 && !st_ff.ready)
    else $error("overflow event did not set flag or clear reading");

  a_ovf_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff.overflow && !(wr_ctrl && req.wdata[FTM_BIT_OVERFLOW])
      |=> st_ff.overflow)
    else $error("overflow flag dropped without a clear");

  // disable and overflow still zero the reading while the flag stands
  a_thr_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff.over_thr && mon_en && !ovf_evt &&
      !(wr_ctrl && req.wdata[FTM_BIT_OVER_THR])
      |=> st_ff.over_thr && $stable(st_ff.reading))
    else $error("over-threshold flag or reading changed");

  a_thr_sets: assert property (@(posedge ref_clk) disable iff (!rst_n)
    thr_evt |=> st_ff.over_thr)
    else $error("count above threshold missed");

  a_capture_cnt: assert property (@(posedge ref_clk) disable iff (!rst_n)
    mon_en && rise && st_ff.armed && !st_ff.over_thr && !st_ff.overflow
      |=> st_ff.reading == $past(st_ff.counter) && st_ff.counter == 8'h00
          && st_ff.ready)
    else $error("capture did not load reading");

  a_read_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)
    rd_speed && !(mon_en && rise) |=> !st_ff.ready)
    else $error("speed read did not clear ready");

  a_irq_level: assert property (@(posedge ref_clk) disable iff (!rst_n)
    st_ff.irq_en && st_ff.overflow && !st_ff.irq_mask_ovf |-> ##1 1'b1
      ##0 ($past(irq) || irq))
    else $error("interrupt not raised");

  a_irq_off: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !st_ff.irq_en |-> !irq)
    else $error("interrupt raised while disabled");

  a_disabled_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !mon_en ##1 !mon_en |-> st_ff.counter == 8'h00 &&
      st_ff.reading == 8'h00)
    else $error("counter or reading not zero while disabled");

endmodule

// ===== design/ftm_pkg.sv
/*
  ftm_pkg: register offsets, field positions, reset values and timing
  constants of the fan tachometer period monitor.
  assumes a 200 MHz system clock and an 8-bit register port.
*/
package ftm_pkg;

  // register offsets on the plain register port
  localparam logic [1:0] FTM_OFS_THRESHOLD = 2'h0;
  localparam logic [1:0] FTM_OFS_READING   = 2'h1;
  localparam logic [1:0] FTM_OFS_CTRL      = 2'h2;
  localparam logic [1:0] FTM_OFS_IRQ_STAT  = 2'h3;

  // control / status field positions
  localparam int FTM_BIT_READY    = 0;
  localparam int FTM_BIT_OVER_THR = 1;
  localparam int FTM_BIT_OVERFLOW = 2;
  localparam int FTM_BIT_IRQ_EN   = 3;
  localparam int FTM_BIT_FILT_DIS = 4;
  localparam int FTM_BIT_CSEL_LO  = 5;

  // reset values
  localparam logic [7:0] FTM_RST_THRESHOLD = 8'hFF;
  localparam logic [1:0] FTM_RST_CSEL      = 2'h1;

  // clock select codes
  localparam logic [1:0] FTM_CSEL_16K = 2'h0;
  localparam logic [1:0] FTM_CSEL_8K  = 2'h1;
  localparam logic [1:0] FTM_CSEL_4K  = 2'h2;
  localparam logic [1:0] FTM_CSEL_2K  = 2'h3;

  // timing
  localparam int FTM_SYS_CLK_HZ    = 200_000_000;
  localparam int FTM_FILT_CLK_HZ   = 32_000;
  localparam int FTM_FILT_MIN_US   = 750;
  // least pulse width in filter ticks, rounded up
  localparam int FTM_FILT_TICKS =
    (FTM_FILT_MIN_US * (FTM_FILT_CLK_HZ / 1000) + 999) / 1000;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ftm_req_s;

  typedef struct packed {
    logic [4:0] cnt;
    logic       level;
  } ftm_filt_s;

  typedef struct packed {
    logic [7:0] threshold;
    logic [7:0] reading;
    logic [7:0] counter;
    logic [1:0] csel;
    logic       filt_dis;
    logic       irq_en;
    logic       overflow;
    logic       over_thr;
    logic       ready;
    logic       irq_mask_ovf;
    logic       irq_mask_thr;
    logic       tach_prev;
    logic       armed;
    logic [7:0] rdata;
    logic       irq;
  } ftm_state_s;

endpackage

// ===== design/ftm_glitch_filter.sv
/*
  ftm_glitch_filter: drops tachometer pulses shorter than the least
  width, sampled on a 32 KHz tick enable.
  assumes tick_en is a one-cycle pulse in the ref_clk domain.
*/
module ftm_glitch_filter
  import ftm_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic tick_en,
  input  wire logic raw_in,
  output logic      filt_out
);
  import ftm_pkg::*;

  ftm_filt_s st_ff;
  ftm_filt_s nxt_st;
  localparam logic [4:0] HOLD_TICKS = 5'(FTM_FILT_TICKS);

  always_comb begin
    nxt_st = st_ff;
    if (tick_en) begin
      // a level must hold for the whole window before it passes
      if (raw_in == st_ff.level) begin
        nxt_st.cnt = '0;
      end else if (st_ff.cnt >= HOLD_TICKS - 5'h1) begin
        nxt_st.level = raw_in;
        nxt_st.cnt   = '0;
      end else begin
        nxt_st.cnt = st_ff.cnt + 5'h1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign filt_out = st_ff.level;

endmodule

// ===== tb/ftm_fan_model.sv
/*
  ftm_fan_model: fan tachometer output for the period monitor bench.
  assumes fire is a one-cycle request from the bench, width in cycles.
*/
module ftm_fan_model (
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic       fire,
  input  wire logic [7:0] width,
  output logic            tach
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_ff;
  // push-pull output, idles low between pulses
  always @(posedge ref_clk) begin
    if (!rst_n)
      left_ff <= 8'h0;
    else if (fire)
      left_ff <= width;
    else if (left_ff != 8'h0)
      left_ff <= left_ff - 8'h1;
  end
  assign tach = (left_ff != 8'h0);
endmodule

// ===== tb/tb_top.sv
/*
  tb_top: register-level bench of ftm_period_monitor with a fan model.
  assumes 200 MHz ref_clk; the bench makes all slow tick enables.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ftm_pkg::*;
  logic       ref_clk = 0, rst_n = 0, mon_en = 0, run32 = 0;
  logic       tick_32k = 0, fire = 0, tach, reg_wr = 0, reg_rd = 0, irq;
  logic [3:0] ticks = 4'h0;
  logic [7:0] width = 8'h3, reg_wdata = 8'h0, reg_rdata, d;
  logic [1:0] reg_addr = 2'h0;
  int         failures = 0, checked = 0;
  always #2.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) tick_32k <= run32 & ~tick_32k;
  ftm_fan_model u_ftm_fan_model (.ref_clk, .rst_n, .fire, .width, .tach);
  ftm_period_monitor u_ftm_period_monitor (.ref_clk, .rst_n, .mon_en,
    .tick_16k(ticks[0]), .tick_8k(ticks[1]), .tick_4k(ticks[2]),
    .tick_2k(ticks[3]), .tick_32k, .tach_pulse_in(tach), .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq);
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(logic [1:0] a, logic [7:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe, so sample mid-cycle
  task automatic rc(string n, logic [1:0] a, logic [7:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    chk(n, e, reg_rdata);
  endtask
  task automatic ci(logic e);
    cyc(2);
    @(negedge ref_clk);
    chk("irq", {7'h0, e}, {7'h0, irq});
  endtask
  task automatic tick(int i, int n);
    repeat (n) begin
      @(posedge ref_clk);
      ticks[i] <= 1'b1;
      @(posedge ref_clk);
      ticks[i] <= 1'b0;
    end
  endtask
  task automatic pulse(int w, int after);
    @(posedge ref_clk);
    width <= 8'(w);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    cyc(w + after);
  endtask
  // config fields only change while the monitor is off
  task automatic restart(logic [7:0] ctrl);
    @(posedge ref_clk);
    mon_en <= 1'b0;
    wr(FTM_OFS_CTRL, ctrl);
    @(posedge ref_clk);
    mon_en <= 1'b1;
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    cyc(100000);
    failures++;
    give_verdict();
  end
  initial begin
    cyc(10);
    rst_n <= 1'b1;
    rc("threshold", FTM_OFS_THRESHOLD, 8'hFF);
    rc("reading", FTM_OFS_READING, 8'h00);
    rc("ctrl", FTM_OFS_CTRL, 8'h20);
    rc("mask", FTM_OFS_IRQ_STAT, 8'h00);
    ci(1'b0);
    $display("test reset done");
    // unselected rates also tick, they must not count
    for (int c = 0; c < 4; c++) begin
      restart({1'b0, c[1:0], 5'h10});
      rc("idle reading", FTM_OFS_READING, 8'h00);
      pulse(3, 4);
      for (int i = 0; i < 4; i++) tick(i, (i == c) ? c + 2 : 3);
      pulse(3, 4);
      rc("ready", FTM_OFS_CTRL, {1'b0, c[1:0], 5'h11});
      rc("reading", FTM_OFS_READING, 8'(c + 2));
      rc("ready clr", FTM_OFS_CTRL, {1'b0, c[1:0], 5'h10});
    end
    tick(3, 2);
    pulse(3, 4);
    rc("next reading", FTM_OFS_READING, 8'h02);
    $display("test clock select done");
    wr(FTM_OFS_THRESHOLD, 8'h03);
    restart(8'h38);
    pulse(3, 4);
    tick(1, 5);
    pulse(3, 4);
    rc("over thr", FTM_OFS_CTRL, 8'h3B);
    ci(1'b1);
    rc("thr reading", FTM_OFS_READING, 8'h05);
    wr(FTM_OFS_IRQ_STAT, 8'h02);
    ci(1'b0);
    wr(FTM_OFS_IRQ_STAT, 8'h00);
    wr(FTM_OFS_CTRL, 8'h38);
    rc("w0 sticky", FTM_OFS_CTRL, 8'h3A);
    ci(1'b1);
    tick(1, 2);
    pulse(3, 4);
    rc("held reading", FTM_OFS_READING, 8'h05);
    wr(FTM_OFS_CTRL, 8'h3A);
    rc("w1c thr", FTM_OFS_CTRL, 8'h38);
    ci(1'b0);
    $display("test threshold done");
    wr(FTM_OFS_THRESHOLD, 8'hFF);
    restart(8'h38);
    pulse(3, 4);
    tick(1, 2);
    pulse(3, 4);
    tick(1, 256);
    rc("overflow", FTM_OFS_CTRL, 8'h3C);
    rc("ovf reading", FTM_OFS_READING, 8'h00);
    ci(1'b1);
    pulse(3, 4);
    rc("ovf sticky", FTM_OFS_CTRL, 8'h3C);
    wr(FTM_OFS_CTRL, 8'h3C);
    ci(1'b0);
    pulse(3, 4);
    tick(1, 4);
    pulse(3, 4);
    rc("resumed", FTM_OFS_READING, 8'h04);
    $display("test overflow done");
    // 32 KHz tick every other cycle: a 20-cycle glitch is 10 ticks
    run32 <= 1'b1;
    restart(8'h20);
    pulse(80, 80);
    tick(1, 3);
    pulse(20, 80);
    tick(1, 2);
    pulse(80, 80);
    rc("filtered", FTM_OFS_READING, 8'h05);
    $display("test filter done");
    give_verdict();
  end
endmodule
